/* File: pkg/irc_defs.svh */
/*
  Constants of the infrared codec control block: register offsets,
  reset value, write mask, bit-cell timing and pulse-filter figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH

// ==========================================================
// register map
`define IRC_CTL_OFS 16'h00BF
`define IRC_STAT_OFS 16'h00C0
`define IRC_CTL_RST 8'h00
`define IRC_CTL_WMASK 8'hF7

// ==========================================================
// bit cell, in baud ticks
`define IRC_BIT_TICKS 5'h10
`define IRC_PHASE_LAST 4'hF
`define IRC_PULSE_FIRST 4'h7
`define IRC_PULSE_LAST 4'h9

// ==========================================================
// receive pulse filter
`define IRC_WIDE_LIMIT 3'h5
`define IRC_CNT_LOW 2'h3

`endif

/* File: pkg/irc_pkg.sv */
/*
  Types of the infrared codec control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package irc_pkg;

  // ==========================================================
  // control register layout
  typedef struct packed {
    logic [3:0] min_pulse;
    logic reserved;
    logic loopback;
    logic infrared_receive_gate;
    logic codec_master_enable;
  } irc_ctl_type;

  // status register layout
  typedef struct packed {
    logic [4:0] zero;
    logic rx_busy;
    logic rxd_level;
    logic tx_level;
  } irc_stat_type;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } irc_bus_req_type;

  // receive filter states
  typedef enum logic {IRC_RX_IDLE, IRC_RX_LOW} irc_rx_state_type;

endpackage

`default_nettype wire

/* File: src/irc_rx_filter.sv */
/*
  Receive pulse filter and decoder: measures low pulses on the
  selected infrared input, rejects narrow and wide ones, and drives
  one bit period of low on the serial receive output per good pulse.
  Assumes rx_level and baud_tick are synchronous to mclk.
*/
`default_nettype none
`include "irc_defs.svh"

module irc_rx_filter
  import irc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0] min_pulse,
  input wire logic baud_tick,
  input wire logic rx_level,
  output logic rxd_out,
  output logic busy,
  output logic accept
);

  irc_rx_state_type st_q, st_d; // pulse measuring state
  logic [5:0] cnt_q, cnt_d; // narrow-pulse down-counter
  logic [2:0] wide_q, wide_d; // baud ticks seen while low
  logic [4:0] drv_q, drv_d; // ticks left of low output
  logic rxd_q, rxd_d; // serial receive output
  logic [5:0] run_q, run_d; // low length, checking only
  logic rx_low; // pulse present

  // counter load: field on top, fixed three below
  function automatic logic [5:0] load_value(input logic [3:0] f);
    load_value = {f, `IRC_CNT_LOW};
  endfunction

  assign rx_low = ~rx_level;
  assign rxd_out = rxd_q;
  assign busy = (st_q == IRC_RX_LOW);

  // ==========================================================
  // next state of the filter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wide_d = wide_q;
    drv_d = drv_q;
    accept = 1'b0;
    run_d = run_q;
    if (!enable) begin
      // gated off: input ignored, output idle
      st_d = IRC_RX_IDLE;
      cnt_d = 6'h00;
      wide_d = 3'h0;
      drv_d = 5'h00;
      run_d = 6'h00;
    end else begin
      case (st_q)
        IRC_RX_IDLE: begin
          if (rx_low) begin
            st_d = IRC_RX_LOW;
            cnt_d = load_value(min_pulse);
            wide_d = {2'h0, baud_tick};
            run_d = 6'h01;
          end
        end
        IRC_RX_LOW: begin
          if (rx_low) begin
            if (cnt_q != 6'h00) begin
              cnt_d = 6'(cnt_q - 6'h01);
            end
            if (baud_tick && wide_q <= `IRC_WIDE_LIMIT) begin
              wide_d = 3'(wide_q + 3'h1); // saturates one above limit
            end
            if (run_q != 6'h3F) begin
              run_d = 6'(run_q + 6'h01);
            end
          end else begin
            st_d = IRC_RX_IDLE;
            // zero field: no minimum width, else full count
            // too many baud ticks always rejects
            accept = (min_pulse == 4'h0 || cnt_q <= 6'h01)
                     && wide_q <= `IRC_WIDE_LIMIT;
          end
        end
        default: begin
          st_d = IRC_RX_IDLE;
        end
      endcase
      // good pulse: one full bit cell of low on the output
      if (accept) begin
        drv_d = `IRC_BIT_TICKS;
      end else if (baud_tick && drv_q != 5'h00) begin
        drv_d = 5'(drv_q - 5'h01);
      end
    end
    rxd_d = (drv_d == 5'h00);
  end

  // registers of the filter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= IRC_RX_IDLE;
      cnt_q <= 6'h00;
      wide_q <= 3'h0;
      drv_q <= 5'h00;
      rxd_q <= 1'b1;
      run_q <= 6'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wide_q <= wide_d;
      drv_q <= drv_d;
      rxd_q <= rxd_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  count_load_a: assert property (
    enable && st_q == IRC_RX_IDLE && rx_low && min_pulse != 4'h0
    |=> cnt_q == load_value($past(min_pulse)))
    else $error("down-counter not loaded from field");

  narrow_reject_a: assert property (
    accept && min_pulse != 4'h0 |-> run_q >= load_value(min_pulse))
    else $error("narrow pulse accepted");

  edge_accept_a: assert property (
    enable && busy && !rx_low && min_pulse == 4'h0
    && wide_q <= `IRC_WIDE_LIMIT |-> accept)
    else $error("short pulse lost with zero field");

  wide_reject_a: assert property (
    accept |-> wide_q <= `IRC_WIDE_LIMIT)
    else $error("wide pulse accepted");

  low_output_a: assert property (
    accept |=> !rxd_out ##1 (!rxd_out || !$past(enable)))
    else $error("good pulse gave no low output");

  pulse_ok_c: cover property (accept ##[1:40] !rxd_out);

endmodule

`default_nettype wire

/* File: src/irc_top.sv */
/*
  Infrared codec control: control and status registers, bit encoder,
  loopback routing and the receive filter between a UART and an
  infrared transceiver.
  Assumes baud_tick is a one-cycle pulse per baud clock (16 per bit)
  from the UART generator, that UART bits start on the tick that
  wraps the phase counter, and all inputs but arst_n are synchronous to mclk.
  Limitations: the encoder phase runs free while the codec is on, so
  the UART has to share its tick grid; nothing in hardware stops
  transmit and receive from running together on the half-duplex
  link, software has to keep them apart.
*/
// What this block does
// - zero field skips the minimum-width check
// - nonzero field loads counter as field then three
// - accept only pulses of at least field*4+3 clocks
// - loopback routes inverted transmit into receive
// - receive gate passes decoded data, else ignored
// - zero bit: seven low, three high, six low
// - pulses over five baud ticks always rejected
// - high line is one; pulse gives low bit
`default_nettype none
`include "irc_defs.svh"

module irc_top
  import irc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire irc_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire logic baud_tick,
  input wire logic uart_txd,
  output logic uart_rxd,
  output logic infrared_transmit_out,
  input wire logic infrared_receive_in
);

  // ==========================================================
  // reset release

  logic rst_meta_q; // first stage, read only by second
  logic rst_n; // released reset for the block

  // two-stage release of the asynchronous reset
  // reset falls at once; its rise waits two edges against metastability
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // register port

  irc_ctl_type ctl_q, ctl_d; // control register
  logic [7:0] rdata_q, rdata_d; // read data, one cycle late
  irc_stat_type stat; // live status view
  logic rx_busy; // filter is measuring a pulse
  logic rxd_level; // filter output level

  // address compare shared by read and write decode
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // status gathers the block's own levels
  always_comb begin
    stat = '0;
    stat.rx_busy = rx_busy;
    stat.rxd_level = rxd_level;
    stat.tx_level = infrared_transmit_out;
  end

  // write decode and read mux
  always_comb begin
    ctl_d = ctl_q;
    rdata_d = 8'h00;
    // write: reserved bit dropped by the mask
    if (bus_req.wr && hit(bus_req.addr, `IRC_CTL_OFS)) begin
      ctl_d = irc_ctl_type'(bus_req.wdata & `IRC_CTL_WMASK);
    end
    // read: data stands only in the following cycle
    if (bus_req.rd) begin
      if (hit(bus_req.addr, `IRC_CTL_OFS)) begin
        rdata_d = ctl_q;
      end else if (hit(bus_req.addr, `IRC_STAT_OFS)) begin
        rdata_d = stat;
      end else begin
        rdata_d = 8'h00; // unmapped reads zero
      end
    end
  end

  // register port flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= irc_ctl_type'(`IRC_CTL_RST);
      rdata_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  // ==========================================================
  // transmit encoder

  logic [3:0] phase_q, phase_d; // baud tick within the bit cell
  logic bit_q, bit_d; // bit being sent, idle is one
  logic tx_q, tx_d; // infrared transmit level

  // pulse window of a zero bit: ticks seven to nine
  function automatic logic in_pulse(input logic [3:0] ph);
    in_pulse = (ph >= `IRC_PULSE_FIRST) && (ph <= `IRC_PULSE_LAST);
  endfunction

  // phase, bit capture and pulse shaping
  always_comb begin
    phase_d = phase_q;
    bit_d = bit_q;
    if (!ctl_q.codec_master_enable) begin
      // codec off: no encoding, line held low
      phase_d = 4'h0;
      bit_d = 1'b1;
    end else if (baud_tick) begin
      phase_d = 4'(phase_q + 4'h1);
      // new bit taken as the cell wraps
      if (phase_q == `IRC_PHASE_LAST) begin
        bit_d = uart_txd;
      end
    end
    // one stays low; zero pulses high in its window
    tx_d = ctl_q.codec_master_enable && !bit_d && in_pulse(phase_d);
  end

  // encoder flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 4'h0;
      bit_q <= 1'b1;
      tx_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
    end
  end

  assign infrared_transmit_out = tx_q;

  // ==========================================================
  // receive path

  logic rx_src; // selected receive level
  logic rx_enable; // filter runs only with both enables
  logic rx_accept; // good pulse seen, one cycle

  // loopback takes the inverted transmit level
  assign rx_src = ctl_q.loopback ? ~tx_q : infrared_receive_in;

  // decoding needs master enable and receive gate
  assign rx_enable = ctl_q.codec_master_enable
                     && ctl_q.infrared_receive_gate;

  // filter and decoder
  irc_rx_filter u_filter (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(rx_enable),
    .min_pulse(ctl_q.min_pulse),
    .baud_tick(baud_tick),
    .rx_level(rx_src),
    .rxd_out(rxd_level),
    .busy(rx_busy),
    .accept(rx_accept)
  );

  // gated off the output idles high
  assign uart_rxd = rxd_level;

  // ==========================================================
  // check helper: baud ticks seen while a pulse is high

  logic [2:0] hi_ticks_q, hi_ticks_d; // ticks inside the current pulse

  // counts ticks of one pulse; cleared while the line is low
  always_comb begin
    hi_ticks_d = 3'h0;
    if (tx_q) begin
      hi_ticks_d = hi_ticks_q;
      // saturates so a stuck line cannot wrap back to a good count
      if (baud_tick && hi_ticks_q != 3'h7) begin
        hi_ticks_d = 3'(hi_ticks_q + 3'h1);
      end
    end
  end

  // helper flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_ticks_q <= 3'h0;
    end else begin
      hi_ticks_q <= hi_ticks_d;
    end
  end

  // ==========================================================
  // checks

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // loopback feeds the filter the inverted transmit level
  loop_route_a: assert property (
    ctl_q.loopback |-> rx_src == !infrared_transmit_out)
    else $error("loopback did not carry inverted transmit");

  // without loopback the filter sees the pin
  loop_off_a: assert property (
    !ctl_q.loopback |-> rx_src == infrared_receive_in)
    else $error("receive pin bypassed without loopback");

  // gate off: filter cleared, UART line idle
  gate_idle_a: assert property (
    !ctl_q.infrared_receive_gate |=> uart_rxd && !rx_busy)
    else $error("receive data passed while gated");

  // with both enables a good pulse reaches the UART
  gate_pass_a: assert property (
    rx_enable && rx_accept |=> !uart_rxd)
    else $error("decoded zero did not reach the UART");

  // codec off: both directions quiet
  codec_off_a: assert property (
    !ctl_q.codec_master_enable |=> !infrared_transmit_out && uart_rxd)
    else $error("codec active while disabled");

  // pulse starts on tick seven of a zero cell
  pulse_start_a: assert property (
    $rose(tx_q) |-> phase_q == `IRC_PULSE_FIRST && !bit_q)
    else $error("transmit pulse started off phase");

  // pulse ends as the phase leaves the window
  pulse_end_a: assert property (
    $past(ctl_q.codec_master_enable) && $fell(tx_q)
    |-> phase_q == 4'(`IRC_PULSE_LAST + 4'h1))
    else $error("transmit pulse ended off phase");

  // pulse lasts exactly three baud ticks
  pulse_len_a: assert property (
    $past(ctl_q.codec_master_enable) && $fell(tx_q)
    |-> hi_ticks_q == 3'(`IRC_PULSE_LAST - `IRC_PULSE_FIRST + 4'h1))
    else $error("transmit pulse of wrong length");

  // high only inside the window of a zero
  pulse_shape_a: assert property (
    tx_q |-> in_pulse(phase_q) && !bit_q)
    else $error("transmit high outside zero-bit window");

  // a one keeps the line low all cell long
  one_quiet_a: assert property (
    bit_q |-> !tx_q)
    else $error("one bit produced a pulse");

  // the next bit is taken only as the cell wraps
  bit_take_a: assert property (
    ctl_q.codec_master_enable && baud_tick && phase_q == `IRC_PHASE_LAST
    |=> bit_q == $past(uart_txd))
    else $error("transmit bit not taken at cell wrap");

  // the bit stays put for the whole sixteen-tick cell
  cell_hold_a: assert property (
    ctl_q.codec_master_enable && phase_q != `IRC_PHASE_LAST |=> $stable(bit_q))
    else $error("transmit bit changed inside its cell");

  // control reads back with the reserved bit clear
  ctl_read_a: assert property (
    bus_req.rd && hit(bus_req.addr, `IRC_CTL_OFS)
    |=> bus_rdata == $past(ctl_q) && !bus_rdata[3])
    else $error("control readback wrong");

  // a write to the control offset lands, reserved bit dropped
  ctl_write_a: assert property (
    bus_req.wr && hit(bus_req.addr, `IRC_CTL_OFS)
    |=> ctl_q == irc_ctl_type'($past(bus_req.wdata) & `IRC_CTL_WMASK))
    else $error("control write did not land");

  // no write, no change
  ctl_hold_a: assert property (
    !(bus_req.wr && hit(bus_req.addr, `IRC_CTL_OFS)) |=> $stable(ctl_q))
    else $error("control changed without a write");

  // status shows the levels of the cycle of the read
  stat_read_a: assert property (
    bus_req.rd && hit(bus_req.addr, `IRC_STAT_OFS)
    |=> bus_rdata == {5'h00, $past(rx_busy), $past(uart_rxd),
                      $past(infrared_transmit_out)})
    else $error("status readback wrong");

  // read data stand one cycle only
  rdata_idle_a: assert property (
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside read cycle");

  // main scenarios
  tx_pulse_c: cover property ($rose(tx_q) ##[1:40] $fell(tx_q));

  loop_accept_c: cover property (ctl_q.loopback && rx_accept);

  filter_on_c: cover property (rx_enable && ctl_q.min_pulse != 4'h0
                                && rx_accept);

  gated_pulse_c: cover property (!rx_enable && !rx_src);

endmodule

`default_nettype wire

/* File: test/irc_xcvr_model.sv */
/*
  Infrared transceiver model: idles its receive line high and drives
  one low pulse of a commanded width, counted in mclk cycles.
  Assumes send is a one-cycle request synchronous to mclk.
*/
`default_nettype none

module irc_xcvr_model (
  input wire logic mclk,
  input wire logic send,
  input wire logic [7:0] width,
  output logic infrared_receive_in,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // pulse timer
  logic [7:0] left_q = 8'h00; // low cycles still to drive

  // line low while the timer runs, idle high otherwise
  assign infrared_receive_in = (left_q == 8'h00);
  assign busy = (left_q != 8'h00);

  // load on request, count down once per cycle
  always_ff @(posedge mclk) begin
    if (send) begin
      left_q <= width;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
endmodule

`default_nettype wire

/* File: test/tb.sv */
/*
  Self-checking bench of the infrared codec control block: register
  accesses, encoder pulse counts, receive filter and loopback.
  Assumes baud_tick every fourth mclk, so one bit cell is 64 mclks.
*/
`default_nettype none
`include "irc_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  error_cnt++; $display("mismatch %0t value differs", $time); end end

  // ==========================================================
  // signals
  logic mclk = 1'b0; // system clock
  logic arst_n = 1'b0; // async reset
  irc_bus_req_type bus_req = '0; // register port request
  logic [7:0] bus_rdata; // read data
  logic baud_tick = 1'b0; // baud enable pulse
  logic [1:0] div_q = 2'h0; // tick divider
  logic uart_txd = 1'b1; // transmit bit
  logic uart_rxd; // decoded receive data
  logic infrared_transmit_out; // encoded output
  logic infrared_receive_in; // model line
  logic send = 1'b0; // pulse request
  logic [7:0] width = 8'h00; // pulse width
  logic xbusy; // model busy
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  // 100 ns period
  always #50 mclk = ~mclk;

  // one baud tick each fourth cycle
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    baud_tick <= (div_q == 2'h3);
  end

  irc_top u_dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .baud_tick(baud_tick),
    .uart_txd(uart_txd),
    .uart_rxd(uart_rxd),
    .infrared_transmit_out(infrared_transmit_out),
    .infrared_receive_in(infrared_receive_in)
  );

  irc_xcvr_model u_xcvr (
    .mclk(mclk),
    .send(send),
    .width(width),
    .infrared_receive_in(infrared_receive_in),
    .busy(xbusy)
  );

  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // read, data taken in the cycle after the strobe
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
  endtask

  // one received pulse; low seen right after its end, or not
  task automatic pulse(input logic [7:0] len, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge mclk);
    send <= 1'b1;
    width <= len;
    @(posedge mclk);
    send <= 1'b0;
    // let the model load before its busy flag is read
    #1;
    repeat (40) if (xbusy === 1'b1) @(posedge mclk);
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (uart_rxd === 1'b0) seen = 1'b1;
    end
    `CHK(seen, e)
    repeat (50) @(posedge mclk);
    #1;
    `CHK(uart_rxd, ~e)
    repeat (30) @(posedge mclk);
    #1;
    `CHK(uart_rxd, 1'b1)
  endtask

  // high cycles of the encoder over one bit cell
  task automatic tx_cnt(input logic b, input int e);
    int n;
    n = 0;
    @(posedge mclk);
    uart_txd <= b;
    repeat (70) @(posedge mclk);
    repeat (64) begin
      @(posedge mclk);
      #1;
      if (infrared_transmit_out === 1'b1) n++;
    end
    `CHK(n, e)
  endtask

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic seen;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_rd(`IRC_CTL_OFS, `IRC_CTL_RST);
    chk_rd(`IRC_STAT_OFS, 8'h02);
    wr(`IRC_CTL_OFS, 8'hFF);
    chk_rd(`IRC_CTL_OFS, 8'hF7);
    chk_rd(16'h00C1, 8'h00);
    // codec off, gate on: no encode, no decode
    wr(`IRC_CTL_OFS, 8'h02);
    tx_cnt(1'b0, 0);
    pulse(8'h0A, 1'b0);
    // codec on, gate off
    wr(`IRC_CTL_OFS, 8'h01);
    pulse(8'h0A, 1'b0);
    tx_cnt(1'b0, 12);
    tx_cnt(1'b1, 0);
    // receive only while transmit idles high
    wr(`IRC_CTL_OFS, 8'h03);
    pulse(8'h01, 1'b1);
    pulse(8'h14, 1'b1);
    pulse(8'h18, 1'b0);
    // threshold field 1..4: just short rejected, exact accepted
    for (int f = 1; f <= 4; f++) begin
      wr(`IRC_CTL_OFS, {f[3:0], 4'h3});
      pulse(8'(f * 4 + 2), 1'b0);
      pulse(8'(f * 4 + 3), 1'b1);
    end
    // mid-run reset: outputs idle at once, register back to reset value
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(uart_rxd, 1'b1)
    `CHK(infrared_transmit_out, 1'b0)
    `CHK(bus_rdata, 8'h00)
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_rd(`IRC_CTL_OFS, `IRC_CTL_RST);
    // internal loopback of a zero bit
    wr(`IRC_CTL_OFS, 8'h07);
    uart_txd <= 1'b0;
    seen = 1'b0;
    repeat (140) begin
      @(posedge mclk);
      #1;
      if (uart_rxd === 1'b0) seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    uart_txd <= 1'b1;
    wr(`IRC_CTL_OFS, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire
